// *** ofiv_capture.v ***
// ofiv_capture.v: analyser capture buffer of thirty-two bytes
// assumes: byte strobe already selected from the chosen framer stream
`timescale 1ns/100ps
`default_nettype none
`include "ofiv_defs.vh"
module ofiv_capture (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // capture side
    input wire restart,
    input wire byte_valid,
    input wire [7:0] byte_data,
    // host read side
    input wire [`OFIV_BUF_AW-1:0] rd_index,
    output reg [7:0] rd_data,
    output wire full
);

reg [7:0] mem [0:`OFIV_BUF_DEPTH-1];
reg [`OFIV_BUF_AW:0] count_reg;

assign full = count_reg[`OFIV_BUF_AW];

////////////////////////////////////////////////////////////////////////////////
// first byte lands at index zero; capture stops once full so nothing overwrites
always @(posedge clk_sys) begin
    if (rst || restart) begin
        count_reg <= 6'h00;
    end else if (byte_valid && !full) begin
        mem[count_reg[`OFIV_BUF_AW-1:0]] <= byte_data;
        count_reg <= count_reg + 6'h01;
    end
end

always @(posedge clk_sys) begin
    if (rst) begin
        rd_data <= 8'h00;
    end else begin
        rd_data <= mem[rd_index];
    end
end

endmodule
`default_nettype wire

// *** ofiv_defs.vh ***
// ofiv_defs.vh: addresses, field positions, reset values and identity constants
// assumes: included by bare name from the block's design files
`ifndef OFIV_DEFS_VH
`define OFIV_DEFS_VH

`define OFIV_ADDR_W 12
`define OFIV_ADDR_VEC1 12'h910
`define OFIV_ADDR_VEC2 12'h911
`define OFIV_ADDR_IDENT 12'h912
`define OFIV_ADDR_ANSTAT 12'h913
`define OFIV_ADDR_MASK_LO 12'h902
`define OFIV_ADDR_MASK_HI 12'h903
`define OFIV_ADDR_BUF_BASE 12'h920
`define OFIV_ADDR_BUF_TOP 12'h93F
`define OFIV_BUF_DEPTH 32
`define OFIV_BUF_AW 5
`define OFIV_NFR 8
`define OFIV_NSTREAM 4
// bit positions inside each framer nibble
`define OFIV_BIT_SYNC 0
`define OFIV_BIT_RXLINE 1
`define OFIV_BIT_ELASTIC 2
`define OFIV_BIT_HDLC 3
// identity value is arbitrary, not any real part's code
`define OFIV_IDENT_CODE 13'h0A5C
`define OFIV_REV_RESET 3'h0
`define OFIV_SRC_RESET 5'h00

`endif

// *** ofiv_host.sv ***
// ofiv_host.sv: host processor model
// assumes: answer one cycle after strobe
`timescale 1ns/100ps
`default_nettype none
module ofiv_host (
    // clock
    input wire logic clk_sys,
    // bus
    output logic cs = 1'b0,
    output logic rd = 1'b0,
    output logic [11:0] addr = 12'h000,
    input wire logic [15:0] rdata,
    input wire logic rdata_valid
);
    // a strobe held past one edge would be a second read
    task automatic rd_word(input logic [11:0] a, output logic [15:0] d);
        {cs, rd, addr} = {2'b11, a};
        @(posedge clk_sys) #1 {cs, rd, addr} = {2'b00, ~a};
        d = rdata_valid ? rdata : 16'hXXXX;
    endtask
endmodule
`default_nettype wire

// *** ofiv_top.v ***
// ofiv_top.v: interrupt vector aggregation, identity and analyser status
// assumes: host bus sync to clk_sys, source status levels from each framer
// assumes: masks and source registers live outside; only their levels arrive here
//
// Contract
// - rx line vector: OR of unmasked status
// - sync vector: OR of unmasked status
// - elastic vector: register or store status
// - hdlc vector: OR of unmasked status
// - set mask forces vector bit low
// - framers 4-7 masks in upper word
// - first word: rx line bit1, sync bit0
// - second word: framers 7..4 nibbles
// - source registers at framer-indexed offsets
// - ident code 15:3, revision 2:0
// - analyser full flag bit0, rest zero
// - buffer byte 7:0, base is first
// - capture any stream of any framer
// - thirty-two readable buffer locations
`timescale 1ns/100ps
`default_nettype none
`include "ofiv_defs.vh"
module ofiv_top (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // host register port
    input wire cs,
    input wire rd,
    input wire wr,
    input wire [`OFIV_ADDR_W-1:0] addr,
    input wire [15:0] wdata,
    output reg [15:0] rdata,
    output wire rdata_valid,
    // per-framer source status, reduced: one bit set means any bit set
    // in the framer's n33/n34/n35/n36 registers after masking
    input wire [`OFIV_NFR-1:0] src_hdlc_any,
    input wire [`OFIV_NFR-1:0] src_sync_any,
    input wire [`OFIV_NFR-1:0] src_rxline_any,
    input wire [`OFIV_NFR-1:0] src_elastic_any,
    input wire [`OFIV_NFR-1:0] elastic_store_event,
    // global mask words, nibble per framer
    input wire [15:0] mask_low_word,
    input wire [15:0] mask_high_word,
    // analyser inputs: one byte strobe per stream per framer
    input wire [`OFIV_NFR*`OFIV_NSTREAM-1:0] stream_byte_valid,
    input wire [`OFIV_NFR*`OFIV_NSTREAM*8-1:0] stream_byte_data,
    input wire [4:0] analyser_source,
    input wire analyser_restart,
    // revision strap
    input wire [2:0] revision_strap
);

////////////////////////////////////////////////////////////////////////////////
// vector gating
// a set mask bit holds its vector bit low whatever the source does
function unmasked;
    input src;
    input mask_bit;
    begin
        unmasked = src & ~mask_bit;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// vector computation
wire [31:0] mask_all = {mask_high_word, mask_low_word};
wire [31:0] vec_next;
reg [31:0] vec_reg;
genvar g;

// live OR, no latching, so clearing the sources drops the bit
generate
    for (g = 0; g < `OFIV_NFR; g = g + 1) begin : g_framer
        wire [3:0] fr_mask;
        wire [3:0] fr_src;
        wire [3:0] fr_vec;

        assign fr_mask = mask_all[4*g +: 4];
        assign fr_src[`OFIV_BIT_SYNC] = src_sync_any[g];
        assign fr_src[`OFIV_BIT_RXLINE] = src_rxline_any[g];
        // the store's own event flag is a second elastic source
        assign fr_src[`OFIV_BIT_ELASTIC] = src_elastic_any[g]
            | elastic_store_event[g];
        assign fr_src[`OFIV_BIT_HDLC] = src_hdlc_any[g];

        assign fr_vec[`OFIV_BIT_SYNC] = unmasked(fr_src[`OFIV_BIT_SYNC],
            fr_mask[`OFIV_BIT_SYNC]);
        assign fr_vec[`OFIV_BIT_RXLINE] = unmasked(fr_src[`OFIV_BIT_RXLINE],
            fr_mask[`OFIV_BIT_RXLINE]);
        assign fr_vec[`OFIV_BIT_ELASTIC] = unmasked(fr_src[`OFIV_BIT_ELASTIC],
            fr_mask[`OFIV_BIT_ELASTIC]);
        assign fr_vec[`OFIV_BIT_HDLC] = unmasked(fr_src[`OFIV_BIT_HDLC],
            fr_mask[`OFIV_BIT_HDLC]);
        // nibble order inside each framer: hdlc, elastic, rx line, sync
        assign vec_next[4*g +: 4] = fr_vec;
    end
endgenerate

// one cycle of lag buys the host a word that never glitches
always @(posedge clk_sys) begin
    if (rst) begin
        vec_reg <= 32'h00000000;
    end else begin
        vec_reg <= vec_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// revision caught on the first clock after reset release
// a later strap change is ignored until the next reset
reg [2:0] revision_field_reg;
reg rev_caught_reg;

always @(posedge clk_sys) begin
    if (rst) begin
        revision_field_reg <= `OFIV_REV_RESET;
        rev_caught_reg <= 1'b0;
    end else if (!rev_caught_reg) begin
        revision_field_reg <= revision_strap;
        rev_caught_reg <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// analyser source select
// registered copy; the live input is compared with it to spot a change
reg [4:0] src_sel_reg;
always @(posedge clk_sys) begin
    if (rst) begin
        src_sel_reg <= `OFIV_SRC_RESET;
    end else begin
        src_sel_reg <= analyser_source;
    end
end

// one strobe and one byte picked out of the thirty-two streams
wire sel_valid = stream_byte_valid[src_sel_reg];
wire [7:0] sel_data = stream_byte_data[src_sel_reg*8 +: 8];

// a source change restarts capture so bytes of two streams never mix
wire cap_restart = analyser_restart | (analyser_source != src_sel_reg);
wire cap_full;
wire [7:0] cap_rd_data;

// buffer index is the low address bits; it only counts inside the window
ofiv_capture u_capture (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(cap_restart),
    .byte_valid(sel_valid),
    .byte_data(sel_data),
    .rd_index(addr[`OFIV_BUF_AW-1:0]),
    .rd_data(cap_rd_data),
    .full(cap_full)
);

////////////////////////////////////////////////////////////////////////////////
// host read decode; buffer read is one cycle deep, so answer the next cycle
// thirty-two word window of the capture buffer
function is_buf;
    input [`OFIV_ADDR_W-1:0] a;
    begin
        is_buf = (a >= `OFIV_ADDR_BUF_BASE) && (a <= `OFIV_ADDR_BUF_TOP);
    end
endfunction

// word seen at a plain register address; holes in the map read as zero
function [15:0] reg_word;
    input [`OFIV_ADDR_W-1:0] a;
    input [31:0] vec;
    input [2:0] rev;
    input full_flag;
    begin
        case (a)
            `OFIV_ADDR_VEC1: reg_word = {14'h0000, vec[1:0]};
            `OFIV_ADDR_VEC2: reg_word = vec[31:16];
            `OFIV_ADDR_IDENT: reg_word = {`OFIV_IDENT_CODE, rev};
            `OFIV_ADDR_ANSTAT: reg_word = {15'h0000, full_flag};
            default: reg_word = 16'h0000;
        endcase
    end
endfunction

// a read is taken on any edge with both strobes high
wire rd_take = cs & rd;
reg rd_pend_reg;
reg rd_buf_reg;
reg [15:0] reg_rdata_reg;

always @(posedge clk_sys) begin
    if (rst) begin
        rd_pend_reg <= 1'b0;
        rd_buf_reg <= 1'b0;
        reg_rdata_reg <= 16'h0000;
    end else begin
        rd_pend_reg <= rd_take;
        // address side runs every cycle; the answer is gated by the strobe later
        rd_buf_reg <= is_buf(addr);
        reg_rdata_reg <= reg_word(addr, vec_reg, revision_field_reg, cap_full);
    end
end

////////////////////////////////////////////////////////////////////////////////
// answer stands one cycle; zero between reads so a stale word never shows
assign rdata_valid = rd_pend_reg;

always @* begin
    if (!rd_pend_reg) begin
        rdata = 16'h0000;
    end else if (rd_buf_reg) begin
        rdata = {8'h00, cap_rd_data};
    end else begin
        rdata = reg_rdata_reg;
    end
end

// writes are accepted and ignored: the vector word is a live view
wire unused_wr = wr | (|wdata);

endmodule
`default_nettype wire

// *** ofiv_top_assertions.sv ***
// ofiv_top_assertions.sv: host port checks
// assumes: bound into ofiv_top
`timescale 1ns/100ps
`default_nettype none
module ofiv_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // bus
    input wire logic cs,
    input wire logic rd,
    input wire logic [11:0] addr,
    input wire logic [15:0] rdata,
    input wire logic rdata_valid,
    // mask words
    input wire logic [15:0] mask_low_word,
    input wire logic [15:0] mask_high_word
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_rd(logic [11:0] a);
        cs && rd && addr == a ##1 rdata_valid;
    endsequence
    chk_read_answer: assert property (cs && rd |=> rdata_valid) else $error("no answer");
    chk_idle_zero: assert property (!rdata_valid |-> rdata == 16'h0000) else $error("idle");
    chk_hole_zero: assert property (s_rd(12'h914) |-> rdata == 16'h0000) else $error("hole");
    chk_answer_cause: assert property (
        rdata_valid |-> $past(cs && rd) && !$past(rst)) else $error("cause");
    chk_ident_code: assert property (
        s_rd(12'h912) |-> rdata[15:3] == 13'h0A5C) else $error("ident");
    chk_vec_pad: assert property (
        s_rd(12'h910) |-> rdata[15:2] == 14'h0000) else $error("pad");
    chk_full_pad: assert property (
        s_rd(12'h913) |-> rdata[15:1] == 15'h0000) else $error("pad");
    chk_byte_pad: assert property (
        cs && rd && addr[11:5] == 7'h49 |=> rdata[15:8] == 8'h00) else $error("pad");
    chk_high_masked: assert property (
        s_rd(12'h911) |-> (rdata & $past(mask_high_word, 2)) == 16'h0000) else $error("mask");
    chk_low_masked: assert property (
        s_rd(12'h910) |-> (rdata[1:0] & $past(mask_low_word[1:0], 2)) == 2'b00)
        else $error("mask");
endmodule
bind ofiv_top ofiv_chk u_chk (.*);
`default_nettype wire

// *** tb.sv ***
// tb.sv: self-checking bench for ofiv_top
// assumes: host model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_sys = 1'b0, rst = 1'b1, cs, rd, rdata_valid;
    logic [11:0] addr;
    logic [15:0] rdata, mask_low_word = 16'h0000, mask_high_word = 16'h0000;
    logic [31:0] s = 32'h0, bv = 32'h0;
    logic [7:0] elastic_store_event = 8'h00;
    logic [4:0] an_src = 5'h0D;
    logic an_restart = 1'b0;
    logic [255:0] bd = {32{8'h40}};
    int error_cnt = 0, n_checks = 0;
    ofiv_top DUT (.*, .wr(1'b0), .wdata(16'h0000), .src_hdlc_any(s[31:24]),
        .src_elastic_any(s[23:16]), .src_rxline_any(s[15:8]), .src_sync_any(s[7:0]),
        .stream_byte_valid(bv), .stream_byte_data(bd), .analyser_source(an_src),
        .analyser_restart(an_restart), .revision_strap(3'h5));
    ofiv_host h (.*);
    initial forever #5 clk_sys = ~clk_sys;
    task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
        n_checks++;
        if (got !== exp) $display("[FAIL] %s exp %h got %h", nm, exp, got);
        if (got !== exp) error_cnt++;
    endtask
    // spare edge first: vector bits lag their sources by one cycle
    task automatic rv(logic [11:0] a, logic [15:0] exp);
        logic [15:0] d;
        @(posedge clk_sys) #1 h.rd_word(a, d);
        chk($sformatf("reg %h", a), d, exp);
    endtask
    task automatic t_vec();
        for (int i = 0; i < 16; i++) begin
            s[8 * (i % 4) + 4 + i / 4] = 1'b1;
            rv(12'h911, 16'h0001 << i);
            s = 32'h0;
            rv(12'h911, 16'h0000);
        end
        s = 32'hFF00_FFFF;
        elastic_store_event = 8'hF0;
        mask_low_word = 16'hFFFF;
        rv(12'h911, 16'hFFFF);
        mask_high_word = 16'hF0FF;
        rv(12'h911, 16'h0F00);
        mask_low_word = 16'h0000;
        rv(12'h910, 16'h0003);
        mask_low_word = 16'h0001;
        rv(12'h910, 16'h0002);
    endtask
    // decoy on stream 12 proves only the chosen stream is captured
    task automatic t_cap();
        rv(12'h912, {13'h0A5C, 3'h5});
        rv(12'h914, 16'h0000);
        bv = 32'h0000_3000;
        for (int n = 1; n < 34; n++) @(posedge clk_sys) #1 bd[111:104] = 8'h40 + 8'(n);
        bv = 32'h0;
        rv(12'h913, 16'h0001);
        for (int n = 0; n < 32; n++) rv(12'h920 + 12'(n), {8'h00, 8'h40 + 8'(n)});
        an_restart = 1'b1;
        @(posedge clk_sys) #1 an_restart = 1'b0;
        rv(12'h913, 16'h0000);
        // a new source restarts capture: framer 7, stream 3
        an_src = 5'h1F;
        bd[255:248] = 8'h7A;
        bv = 32'h8000_0000;
        repeat (33) @(posedge clk_sys);
        #1 bv = 32'h0;
        rv(12'h913, 16'h0001);
        rv(12'h93F, 16'h007A);
        // a reset in mid-run clears the full flag again
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 rst = 1'b0;
        rv(12'h913, 16'h0000);
    endtask
    task automatic close_out();
        if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        #1 rst = 1'b0;
        t_vec();
        t_cap();
        close_out();
    end
endmodule
`default_nettype wire
